// ---- rtl/acmp_pkg.sv ----
package acmp_pkg;

  // register offsets on the plain register port
  localparam int unsigned REG_AW = 3;
  localparam int unsigned REG_DW = 8;
  localparam logic [REG_AW-1:0] OFS_CTRL_STATUS = 3'h0;
  localparam logic [REG_AW-1:0] OFS_SHARED_FUNC = 3'h1;
  localparam logic [REG_AW-1:0] OFS_EVT_STATUS  = 3'h2;
  localparam logic [REG_AW-1:0] OFS_EVT_MASK    = 3'h3;

  // comparator_control_status fields
  localparam int unsigned BIT_DISABLE = 7;
  localparam int unsigned BIT_BANDGAP = 6;
  localparam int unsigned BIT_OUT     = 5;
  localparam int unsigned BIT_FLAG    = 4;
  localparam int unsigned BIT_IE      = 3;
  localparam int unsigned BIT_CAPTURE = 2;
  localparam int unsigned BIT_MODE_HI = 1;
  localparam int unsigned BIT_MODE_LO = 0;

  // shared_function_control field
  localparam int unsigned BIT_MUX_EN = 3;

  // event status / mask layout
  localparam int unsigned EVT_W      = 2;
  localparam int unsigned EVT_MATCH  = 0;
  localparam int unsigned EVT_TOGGLE = 1;

  // reset values
  localparam logic [1:0]       MODE_RESET  = 2'h0;
  localparam logic [EVT_W-1:0] EVT_RESET   = 2'h0;
  localparam logic [REG_DW-1:0] DATA_RESET = 8'h00;

  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'h0,
    MODE_RSVD   = 2'h1,
    MODE_FALL   = 2'h2,
    MODE_RISE   = 2'h3
  } event_mode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
  } reg_req_t;

endpackage

// ---- rtl/level_sync.sv ----
`timescale 1ns/1ps
module level_sync
  import acmp_pkg::*;
#(
  parameter int unsigned STAGES = SYNC_STAGES
)(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic [STAGES-1:0] chain;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  if (STAGES < 2)
  begin : g_chk
    $error("level_sync needs at least two stages");
  end

  // first stage feeds only the second
  always_comb
  begin
    st_d.chain = {st_q.chain[STAGES-2:0], d};
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q = st_q.chain[STAGES-1];

endmodule // level_sync

// ---- rtl/analog_comparator_control.sv ----
// How it works
// R1: raw result high when positive exceeds negative
// R2: output status synchronised, lags two cycles
// R3: disable bit powers comparator down
// R4: bandgap select replaces positive input pin
// R5: matching output edge sets event flag
// R6: vector acknowledge or written one clears flag
// R7: interrupt needs flag, enable and global enable
// R8: capture route links output to timer capture
// R9: mode field picks toggle, fall or rise
// R10: software disables interrupt before changing mode
// R11: software disables interrupt before changing disable
// R12: negative pin unless mux borrowed
// R13: channel select picks borrowed negative channel
// R14: converter enable decides if mux borrowable
// R15: edges found against previous output; reserved silent
`timescale 1ns/1ps
module analog_comparator_control
  import acmp_pkg::*;
#(
  parameter int unsigned VW  = 10,
  parameter int unsigned NCH = 8,
  parameter int unsigned CSW = 3
)(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire reg_req_t                bus_req,
  output logic [REG_DW-1:0]            rdata,
  input  wire logic [VW-1:0]           positive_input_pin,
  input  wire logic [VW-1:0]           negative_input_pin,
  input  wire logic [VW-1:0]           bandgap_level,
  input  wire logic [NCH-1:0][VW-1:0]  analog_channel_pins,
  input  wire logic [CSW-1:0]          channel_select,
  input  wire logic                    converter_enable,
  input  wire logic                    global_irq_enable,
  input  wire logic                    irq_vector_ack,
  output logic                         comparator_powered,
  output logic                         comparator_output_status,
  output logic                         comparator_irq_req,
  output logic                         capture_trigger,
  output logic                         irq
);

  if (VW < 1)
  begin : g_chk_vw
    $error("level width must be at least one bit");
  end
  if (NCH != (1 << CSW))
  begin : g_chk_nch
    $error("channel count must match channel select width");
  end

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic              dis;
    logic              bg;
    logic              flag;
    logic              ie;
    logic              cap;
    event_mode_t       mode;
    logic              mux_en;
    logic              out_prev;
    logic [EVT_W-1:0]  evt_sts;
    logic [EVT_W-1:0]  evt_msk;
    logic [REG_DW-1:0] rdata;
  } ctrl_state_t;

  ctrl_state_t st_q;
  ctrl_state_t st_d;

  logic [VW-1:0]     pos_level;
  logic [VW-1:0]     neg_level;
  logic              mux_borrowed;
  logic              raw_result;
  logic              out_sync;
  logic              rise;
  logic              fall;
  logic              match;
  logic [EVT_W-1:0]  evt_hit;
  logic [REG_DW-1:0] ctrl_view;
  logic [REG_DW-1:0] wd;
  logic              wr_ctrl;
  logic              wr_func;
  logic              wr_sts;
  logic              wr_msk;

  ////////////////////////////////////////////////////////////////////////////
  // input selection and comparison

  // converter multiplexer only when converter is off
  assign mux_borrowed = st_q.mux_en && !converter_enable; // R12 R14

  always_comb
  begin
    pos_level = st_q.bg ? bandgap_level : positive_input_pin; // R4
    if (mux_borrowed)
      neg_level = analog_channel_pins[channel_select]; // R13
    else
      neg_level = negative_input_pin; // R12
  end

  // powered down core drives a steady low
  assign raw_result = !st_q.dis && (pos_level > neg_level); // R1 R3
  assign comparator_powered = !st_q.dis; // R3

  level_sync #(
    .STAGES (SYNC_STAGES)
  ) u_out_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (raw_result),
    .q       (out_sync)
  ); // R2

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and event selection

  assign rise = out_sync && !st_q.out_prev; // R15
  assign fall = !out_sync && st_q.out_prev; // R15

  always_comb
  begin
    unique case (st_q.mode)
      MODE_TOGGLE: match = rise || fall; // R9
      MODE_FALL:   match = fall; // R9
      MODE_RISE:   match = rise; // R9
      MODE_RSVD:   match = 1'b0; // R15
    endcase
  end

  always_comb
  begin
    evt_hit             = '0;
    evt_hit[EVT_MATCH]  = match;
    evt_hit[EVT_TOGGLE] = rise || fall;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  assign wd      = bus_req.wdata;
  assign wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL_STATUS);
  assign wr_func = bus_req.wr && (bus_req.addr == OFS_SHARED_FUNC);
  assign wr_sts  = bus_req.wr && (bus_req.addr == OFS_EVT_STATUS);
  assign wr_msk  = bus_req.wr && (bus_req.addr == OFS_EVT_MASK);

  always_comb
  begin
    ctrl_view              = '0;
    ctrl_view[BIT_DISABLE] = st_q.dis;
    ctrl_view[BIT_BANDGAP] = st_q.bg;
    ctrl_view[BIT_OUT]     = out_sync; // R2
    ctrl_view[BIT_FLAG]    = st_q.flag;
    ctrl_view[BIT_IE]      = st_q.ie;
    ctrl_view[BIT_CAPTURE] = st_q.cap;
    ctrl_view[BIT_MODE_HI] = st_q.mode[1];
    ctrl_view[BIT_MODE_LO] = st_q.mode[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_d          = st_q;
    st_d.out_prev = out_sync; // R15

    if (wr_ctrl)
    begin
      st_d.dis  = wd[BIT_DISABLE]; // R3
      st_d.bg   = wd[BIT_BANDGAP];
      st_d.ie   = wd[BIT_IE];
      st_d.cap  = wd[BIT_CAPTURE];
      st_d.mode = event_mode_t'({wd[BIT_MODE_HI], wd[BIT_MODE_LO]});
    end
    if (wr_func)
      st_d.mux_en = wd[BIT_MUX_EN];
    if (wr_msk)
      st_d.evt_msk = wd[EVT_W-1:0];

    // a new event outranks a clear in the same cycle
    st_d.flag = match
             || (st_q.flag
                 && !irq_vector_ack
                 && !(wr_ctrl && wd[BIT_FLAG])); // R5 R6
    st_d.evt_sts = evt_hit
                 | (st_q.evt_sts & ~(wr_sts ? wd[EVT_W-1:0] : EVT_RESET));

    st_d.rdata = DATA_RESET;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        OFS_CTRL_STATUS: st_d.rdata = ctrl_view;
        OFS_SHARED_FUNC: st_d.rdata[BIT_MUX_EN] = st_q.mux_en;
        OFS_EVT_STATUS:  st_d.rdata[EVT_W-1:0] = st_q.evt_sts;
        OFS_EVT_MASK:    st_d.rdata[EVT_W-1:0] = st_q.evt_msk;
        default:         st_d.rdata = DATA_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q          <= '0;
      st_q.mode     <= MODE_TOGGLE;
      st_q.evt_sts  <= EVT_RESET;
      st_q.evt_msk  <= EVT_RESET;
      st_q.rdata    <= DATA_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata                    = st_q.rdata;
  assign comparator_output_status = out_sync; // R2
  assign comparator_irq_req       = st_q.flag && st_q.ie
                                    && global_irq_enable; // R7
  assign capture_trigger          = st_q.cap && out_sync; // R8
  assign irq                      = |(st_q.evt_sts & st_q.evt_msk);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // plain pins on both inputs, checked from the ports
  a_raw_compare_level: assert property ( // R1
    (!st_q.dis && !st_q.bg && (!st_q.mux_en || converter_enable))
    |-> raw_result == (positive_input_pin > negative_input_pin))
    else $error("raw result does not follow input levels");

  // no sampled history before the first edge out of reset
  a_output_sync_lag: assert property ( // R2
    rst_n |-> ##2 (comparator_output_status == $past(raw_result, 2)))
    else $error("output status not two cycles behind raw");

  a_disable_forces_low: assert property ( // R3
    st_q.dis |-> !raw_result ##2 !comparator_output_status)
    else $error("disabled comparator still drives high");

  a_bandgap_pos_select: assert property ( // R4
    (!st_q.dis && st_q.bg && (!st_q.mux_en || converter_enable))
    |-> raw_result == (bandgap_level > negative_input_pin))
    else $error("positive input selection wrong");

  a_rise_sets_flag: assert property ( // R5
    (st_q.mode == MODE_RISE && !out_sync ##1 out_sync && !$past(wr_ctrl))
    |=> st_q.flag)
    else $error("rising edge did not set the flag");

  a_fall_mode_no_rise: assert property ( // R9
    (st_q.mode == MODE_FALL && !st_q.flag && rise && !wr_ctrl)
    |=> !st_q.flag)
    else $error("rising edge set flag in falling mode");

  a_fall_sets_flag: assert property ( // R5
    (st_q.mode == MODE_FALL && $fell(comparator_output_status))
    |=> st_q.flag)
    else $error("falling edge did not set the flag");

  a_toggle_sets_flag: assert property ( // R9
    (st_q.mode == MODE_TOGGLE && $changed(comparator_output_status))
    |=> st_q.flag)
    else $error("output toggle did not set the flag");

  a_toggle_status_set: assert property ( // R5
    $changed(comparator_output_status) |=> st_q.evt_sts[EVT_TOGGLE])
    else $error("toggle event not recorded in status");

  a_irq_from_toggle: assert property ( // R5
    ($changed(comparator_output_status) ##1 st_q.evt_msk[EVT_TOGGLE])
    |-> irq)
    else $error("unmasked event did not raise the interrupt");

  a_ack_clears_flag: assert property ( // R6
    (st_q.flag && irq_vector_ack && !match) |=> !st_q.flag)
    else $error("vector acknowledge did not clear flag");

  a_flag_w1c: assert property ( // R6
    (st_q.flag && bus_req.wr && bus_req.addr == OFS_CTRL_STATUS
     && bus_req.wdata[BIT_FLAG] && !match) |=> !st_q.flag)
    else $error("written one did not clear the flag");

  a_flag_held: assert property ( // R6
    (st_q.flag && !irq_vector_ack
     && !(bus_req.wr && bus_req.addr == OFS_CTRL_STATUS)) |=> st_q.flag)
    else $error("flag cleared without a clear request");

  a_irq_request_gate: assert property ( // R7
    (st_q.ie && global_irq_enable && $past(match)) |-> comparator_irq_req)
    else $error("interrupt request missing after event");

  a_irq_request_masked: assert property ( // R7
    !(st_q.ie && global_irq_enable) |-> !comparator_irq_req)
    else $error("interrupt request while not enabled");

  a_capture_route: assert property ( // R8
    !st_q.cap |-> !capture_trigger)
    else $error("capture path driven while route disabled");

  a_capture_follows: assert property ( // R8
    st_q.cap |-> capture_trigger == comparator_output_status)
    else $error("capture path does not follow the output");

  a_neg_pin_default: assert property ( // R12
    (!st_q.mux_en || converter_enable) |-> neg_level == negative_input_pin)
    else $error("negative pin not applied");

  a_mux_channel_pick: assert property ( // R13
    (st_q.mux_en && !converter_enable)
    |-> neg_level == analog_channel_pins[channel_select])
    else $error("borrowed channel not applied");

  a_reserved_silent: assert property ( // R15
    (st_q.mode == MODE_RSVD && !st_q.flag) |=> !st_q.flag)
    else $error("reserved mode raised an event");

  a_read_next_cycle: assert property (
    (bus_req.rd && bus_req.addr == OFS_EVT_MASK)
    |=> rdata[EVT_W-1:0] == $past(st_q.evt_msk))
    else $error("mask read data wrong");

  a_unmapped_read_zero: assert property (
    (bus_req.rd && bus_req.addr > OFS_EVT_MASK) |=> rdata == DATA_RESET)
    else $error("unmapped read returned data");

  a_rdata_idle_zero: assert property (
    !bus_req.rd |=> rdata == DATA_RESET)
    else $error("read data outside its cycle");

  c_rise_event:   cover property (st_q.mode == MODE_RISE && match);
  c_fall_event:   cover property (st_q.mode == MODE_FALL && match);
  c_toggle_event: cover property (st_q.mode == MODE_TOGGLE && match);
  c_mux_borrowed: cover property (mux_borrowed && raw_result);
  c_flag_acked:   cover property (st_q.flag && irq_vector_ack);

endmodule // analog_comparator_control

// ---- verif/acmp_analog_model.sv ----
`timescale 1ns/1ps
module acmp_analog_model
  import acmp_pkg::*;
#(
  parameter int unsigned VW   = 10,
  parameter int unsigned NCH  = 8,
  parameter int          SEED = 32'hfef1
)(
  input  wire logic              ref_clk,
  output logic [VW-1:0]          pos_lvl,
  output logic [VW-1:0]          neg_lvl,
  output logic [VW-1:0]          bg_lvl,
  output logic [NCH-1:0][VW-1:0] ch_lvl
);
  int          seed = SEED;
  int          hold = 0;
  logic [127:0] rnd;

  ////////////////////////////////////////
  // levels settle for one to four cycles, like a slow analog front end
  initial
  begin
    {pos_lvl, neg_lvl, bg_lvl, ch_lvl} = '0;
  end

  always @(posedge ref_clk)
  begin
    if (hold > 0)
      hold <= hold - 1;
    else
    begin
      hold <= $random(seed) & 3;
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      {pos_lvl, neg_lvl, bg_lvl, ch_lvl} <= rnd[VW*(NCH+3)-1:0];
    end
  end
endmodule // acmp_analog_model

// ---- verif/tb_analog_comparator_control.sv ----
`timescale 1ns/1ps
module tb_analog_comparator_control
  import acmp_pkg::*;
;
  localparam int unsigned VW  = 10;
  localparam int unsigned NCH = 8;
  logic                   ref_clk = 1'b0;
  logic                   rst_n = 1'b0;
  reg_req_t               bus_req = '0;
  logic [2:0]             channel_select = 3'h0;
  logic                   converter_enable = 1'b0;
  logic                   global_irq_enable = 1'b0;
  logic                   irq_vector_ack = 1'b0;
  logic [7:0]             rdata;
  logic [VW-1:0]          pos, neg, bg;
  logic [NCH-1:0][VW-1:0] ch;
  logic                   powered, out_st, irq_req, cap, irq;
  int                     seed = 32'hfef1;
  int                     n_mismatch = 0;
  int                     num_checks = 0;
  logic [7:0]             m_ctrl, m_rdata;
  logic [1:0]             m_evt, m_mask;
  logic                   m_mux, m_flag, s1, s2, s2p;

  always #20 ref_clk = ~ref_clk;

  analog_comparator_control u_analog_comparator_control (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .positive_input_pin(pos), .negative_input_pin(neg),
    .bandgap_level(bg), .analog_channel_pins(ch),
    .channel_select(channel_select), .converter_enable(converter_enable),
    .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack),
    .comparator_powered(powered), .comparator_output_status(out_st),
    .comparator_irq_req(irq_req), .capture_trigger(cap), .irq(irq));

  acmp_analog_model u_acmp_analog_model (
    .ref_clk(ref_clk), .pos_lvl(pos), .neg_lvl(neg), .bg_lvl(bg),
    .ch_lvl(ch));

  ////////////////////////////////////////
  always @(posedge ref_clk or negedge rst_n)
  begin : model
    logic          raw, tgl, match, clr;
    logic [VW-1:0] p, n;
    if (!rst_n)
      {m_ctrl, m_rdata, m_evt, m_mask, m_mux, m_flag, s1, s2, s2p} = '0;
    else
    begin
      p = m_ctrl[6] ? bg : pos;
      n = (m_mux && !converter_enable) ? ch[channel_select] : neg;
      raw = !m_ctrl[7] && (p > n);
      tgl = s2 != s2p;
      case (m_ctrl[1:0])
        2'h0: match = tgl;
        2'h2: match = tgl && !s2;
        2'h3: match = tgl && s2;
        default: match = 1'b0;
      endcase
      m_rdata = 8'h00;
      if (bus_req.rd)
        case (bus_req.addr)
          3'h0: m_rdata = {m_ctrl[7:6], s2, m_flag, m_ctrl[3:0]};
          3'h1: m_rdata = {4'h0, m_mux, 3'h0};
          3'h2: m_rdata = {6'h0, m_evt};
          3'h3: m_rdata = {6'h0, m_mask};
          default: m_rdata = 8'h00;
        endcase
      clr = bus_req.wr && bus_req.addr == 3'h0 && bus_req.wdata[4];
      m_flag = match | (m_flag & !irq_vector_ack & !clr);
      if (bus_req.wr && bus_req.addr == 3'h2)
        m_evt = m_evt & ~bus_req.wdata[1:0];
      m_evt = m_evt | {tgl, match};
      if (bus_req.wr && bus_req.addr == 3'h0)
        m_ctrl = {bus_req.wdata[7:6], 2'h0, bus_req.wdata[3:0]};
      if (bus_req.wr && bus_req.addr == 3'h1)
        m_mux = bus_req.wdata[3];
      if (bus_req.wr && bus_req.addr == 3'h3)
        m_mask = bus_req.wdata[1:0];
      s2p = s2;
      s2 = s1;
      s1 = raw;
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(negedge ref_clk)
  begin
    check("rdata", rdata, m_rdata);
    check("output", {7'h0, out_st}, {7'h0, s2});
    check("powered", {7'h0, powered}, {7'h0, !m_ctrl[7]});
    check("irq_req", {7'h0, irq_req},
          {7'h0, m_flag & m_ctrl[3] & global_irq_enable});
    check("capture", {7'h0, cap}, {7'h0, m_ctrl[2] & s2});
    check("irq", {7'h0, irq}, {7'h0, |(m_evt & m_mask)});
  end

  ////////////////////////////////////////
  task automatic cycle();
    reg_req_t r;
    logic [31:0] v;
    @(negedge ref_clk);
    v = $random(seed);
    r = '0;
    r.addr = 3'($random(seed));
    r.wdata = 8'($random(seed));
    r.wr = v[17:16] == 2'h1;
    r.rd = v[17:16] == 2'h2;
    if (r.wr && r.addr == 3'h0)
    begin
      if (bus_req.wr && bus_req.addr == 3'h0)
        r.wr = 1'b0;
      else if (m_ctrl[3] && (r.wdata[7] != m_ctrl[7] ||
               r.wdata[1:0] != m_ctrl[1:0]))
        r.wdata = {m_ctrl[7:6], 2'h0, 1'b0, m_ctrl[2:0]};
    end
    @(posedge ref_clk);
    bus_req <= r;
    irq_vector_ack <= v[3:0] == 4'h0;
    if (v[7:4] == 4'h0)
      global_irq_enable <= v[8];
    if (v[11:9] == 3'h0)
      {converter_enable, channel_select} <= v[15:12];
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3000) cycle();
    @(posedge ref_clk);
    bus_req <= '0;
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2000) cycle();
    wrap_up();
  end
endmodule // tb_analog_comparator_control
